/* File: nchc_dev_model.sv */
// behavioural nand device facing the host controller
`timescale 1ns/100ps
module nchc_dev_model #(
  parameter logic [7:0]  ID_CMD  = 8'hA5,
  parameter logic [7:0]  ECC_CMD = 8'h7A,
  parameter logic [39:0] IDS     = 40'h0
) (
  input  wire logic        ce_n,
  input  wire logic        cle,
  input  wire logic        ale,
  input  wire logic        we_n,
  input  wire logic        re_n,
  input  wire logic        wp_n,
  input  wire logic [7:0]  din,
  input  wire logic        fail,
  input  wire logic        unc,
  input  wire logic [31:0] ecc,
  input  int               busy_ns,
  output logic      [7:0]  dq,
  output logic             rb
);
  logic [7:0] pbuf [0:2111];
  logic [7:0] a [0:4];
  logic [1:0] mode = 2'h0;
  logic       pf = 1'b0;
  logic       rdu = 1'b0;
  int acnt = 0, idx = 0, col = 0, row = 0, prow = 0, nprog = 0, ncmd = 0;
  initial rb = 1'b1;
  initial dq = 8'h00;
  ////////////////////////////////////////////////////////////
  always @(posedge we_n) if (!ce_n) begin
    if (cle) begin
      ncmd++;
      acnt = 0;
      idx = 0;
      case (din)
        8'h70: mode = 2'h1;
        ID_CMD: mode = 2'h2;
        ECC_CMD: mode = 2'h3;
        8'h35: begin
          for (int c = 0; c < 2112; c++) pbuf[c] = 8'(row + c);
          rdu = unc;
          pf = 1'b0;
          mode = 2'h0;
          rb = 1'b0;
          rb <= #(busy_ns) 1'b1;
        end
        8'h10: begin
          prow = row;
          nprog++;
          pf = fail;
          rdu = 1'b0;
          mode = 2'h0;
          rb = 1'b0;
          rb <= #(busy_ns) 1'b1;
        end
        default: mode = 2'h0;
      endcase
    end else if (ale) begin
      if (acnt < 5) a[acnt] = din;
      acnt++;
      if (acnt == 2) col = int'({a[1], a[0]});
      if (acnt == 5) row = int'({a[4], a[3], a[2]});
    end else if (col < 2112) begin
      pbuf[col] = din;
      col++;
    end
  end
  ////////////////////////////////////////////////////////////
  always @(negedge re_n) if (!ce_n) begin
    case (mode)
      2'h1: dq = {wp_n, rb, rb, 4'h0, rb ? (pf | rdu) : !pf};
      2'h2: dq = IDS[8*idx +: 8];
      2'h3: dq = ecc[8*idx +: 8];
      default: dq = dq ^ 8'hA5;
    endcase
    idx = (idx + 1) % 5;
  end
  // released bus shows the inverse of the last byte
  always @(posedge re_n) dq = ~dq;
endmodule : nchc_dev_model

/* File: nchc_host.sv */
// nand host controller: copy-back, identification, status and ecc status readout
`timescale 1ns/100ps
module nchc_host (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             nand_ce_n,
  output logic             nand_cle,
  output logic             nand_ale,
  output logic             nand_we_n,
  output logic             read_strobe_n,
  output logic             nand_wp_n,
  output logic      [7:0]  data_port_o,
  output logic             data_port_oe,
  input  wire logic [7:0]  data_port_i,
  input  wire logic        ready_busy_pin
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  nchc_pkg::nchc_state_t state_r;
  nchc_pkg::nchc_op_t    op_r;
  nchc_pkg::nchc_kind_t  kind_c;
  logic [7:0]  byte_c;
  logic [7:0]  din_s;
  logic        rdy_s;
  logic [4:0]  step_r;
  logic [3:0]  ph_r;
  logic [2:0]  rd_cnt_r;
  logic [7:0]  smp_r;
  logic [7:0]  last_cmd_r;
  logic        mod_en_r;
  logic        wp_n_r;
  logic [16:0] src_row_r;
  logic [16:0] dst_row_r;
  logic [11:0] mod_col_r;
  logic [7:0]  mod_data_r;
  logic [7:0]  id_cmd_r;
  logic [7:0]  ecc_cmd_r;
  logic        done_r;
  logic        err_dist_r;
  logic        err_unc_r;
  logic        fail_r;
  logic        ecc_unc_r;
  logic [7:0]  stat_r;
  logic [7:0]  id_r [nchc_pkg::ID_BYTES];
  logic [7:0]  ecc_r [nchc_pkg::ECC_SECTORS];
  logic        run;
  logic        wr_type;
  logic        go;
  logic        dist_bad;
  logic        rd_end;
  logic        cb_check;
  logic        cb_final;
  logic        abort;
  logic        repeat_rd;

  // row address byte n of a 17-bit page/block row
  function automatic logic [7:0] row_byte(input logic [16:0] row, input logic [1:0] n);
    case (n)
      2'h0:    row_byte = row[7:0];
      2'h1:    row_byte = row[15:8];
      default: row_byte = {7'h00, row[16]};
    endcase
  endfunction : row_byte

  nchc_sync #(.W(9)) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .din      ({ready_busy_pin, data_port_i}),
    .dout     ({rdy_s, din_s})
  );

  ////////////////////////////////////////////////////////////////////////////////
  // step decode

  always_comb begin
    kind_c = nchc_pkg::K_END;
    byte_c = 8'h00;
    case (op_r)
      nchc_pkg::OP_COPY: begin
        case (step_r)
          5'h00: begin kind_c = nchc_pkg::K_CMD; byte_c = nchc_pkg::CMD_READ; end
          5'h01, 5'h02: kind_c = nchc_pkg::K_ADR;
          5'h03, 5'h04, 5'h05: begin
            kind_c = nchc_pkg::K_ADR;
            byte_c = row_byte(src_row_r, 2'(step_r - 5'h03));
          end
          5'h06: begin kind_c = nchc_pkg::K_CMD; byte_c = nchc_pkg::CMD_CB_READ; end
          5'h07: kind_c = nchc_pkg::K_WAIT;
          5'h08: begin kind_c = nchc_pkg::K_CMD; byte_c = nchc_pkg::CMD_STATUS; end
          5'h09: kind_c = nchc_pkg::K_RD;
          5'h0A: begin kind_c = nchc_pkg::K_CMD; byte_c = nchc_pkg::CMD_CB_INPUT; end
          5'h0B, 5'h0C: kind_c = nchc_pkg::K_ADR;
          5'h0D, 5'h0E, 5'h0F: begin
            kind_c = nchc_pkg::K_ADR;
            byte_c = row_byte(dst_row_r, 2'(step_r - 5'h0D));
          end
          // optional in-buffer modification
          5'h10: begin
            kind_c = mod_en_r ? nchc_pkg::K_CMD : nchc_pkg::K_NOP;
            byte_c = nchc_pkg::CMD_CB_INPUT;
          end
          5'h11: begin
            kind_c = mod_en_r ? nchc_pkg::K_ADR : nchc_pkg::K_NOP;
            byte_c = mod_col_r[7:0];
          end
          5'h12: begin
            kind_c = mod_en_r ? nchc_pkg::K_ADR : nchc_pkg::K_NOP;
            byte_c = {4'h0, mod_col_r[11:8]};
          end
          5'h13: begin
            kind_c = mod_en_r ? nchc_pkg::K_WR : nchc_pkg::K_NOP;
            byte_c = mod_data_r;
          end
          5'h14: begin kind_c = nchc_pkg::K_CMD; byte_c = nchc_pkg::CMD_PROG; end
          5'h15: kind_c = nchc_pkg::K_WAIT;
          5'h16: begin kind_c = nchc_pkg::K_CMD; byte_c = nchc_pkg::CMD_STATUS; end
          5'h17: kind_c = nchc_pkg::K_RD;
          default: kind_c = nchc_pkg::K_END;
        endcase
      end
      nchc_pkg::OP_ID: begin
        case (step_r)
          5'h00: begin kind_c = nchc_pkg::K_CMD; byte_c = id_cmd_r; end
          5'h01: kind_c = nchc_pkg::K_ADR;
          5'h02, 5'h03, 5'h04, 5'h05, 5'h06: kind_c = nchc_pkg::K_RD;
          default: kind_c = nchc_pkg::K_END;
        endcase
      end
      nchc_pkg::OP_STATUS: begin
        case (step_r)
          5'h00: begin kind_c = nchc_pkg::K_CMD; byte_c = nchc_pkg::CMD_STATUS; end
          5'h01: kind_c = nchc_pkg::K_RD;
          default: kind_c = nchc_pkg::K_END;
        endcase
      end
      default: begin
        case (step_r)
          5'h00: begin kind_c = nchc_pkg::K_CMD; byte_c = ecc_cmd_r; end
          5'h01, 5'h02, 5'h03, 5'h04: kind_c = nchc_pkg::K_RD;
          default: kind_c = nchc_pkg::K_END;
        endcase
      end
    endcase
  end

  assign run       = (state_r == nchc_pkg::ST_RUN);
  assign wr_type   = (kind_c == nchc_pkg::K_CMD) || (kind_c == nchc_pkg::K_ADR) ||
                     (kind_c == nchc_pkg::K_WR);
  assign go        = reg_wr && (reg_addr == nchc_pkg::REG_CTRL) &&
                     reg_wdata[nchc_pkg::CTRL_GO] && !run;
  assign dist_bad  = (nchc_pkg::nchc_op_t'(reg_wdata[nchc_pkg::CTRL_OP +: 2]) ==
                      nchc_pkg::OP_COPY) &&
                     (src_row_r[nchc_pkg::DISTRICT_BIT] != dst_row_r[nchc_pkg::DISTRICT_BIT]);
  assign rd_end    = run && (kind_c == nchc_pkg::K_RD) && (ph_r == nchc_pkg::RD_END_PH);
  assign cb_check  = (op_r == nchc_pkg::OP_COPY) && (step_r == nchc_pkg::STEP_CB_CHECK);
  assign cb_final  = (op_r == nchc_pkg::OP_COPY) && (step_r == nchc_pkg::STEP_CB_FINAL);
  assign abort     = rd_end && cb_check && smp_r[0];
  assign repeat_rd = rd_end && cb_final && !smp_r[6];

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r  <= nchc_pkg::ST_IDLE;
      step_r   <= 5'h00;
      ph_r     <= 4'h0;
      rd_cnt_r <= 3'h0;
    end else if (!run) begin
      step_r   <= 5'h00;
      ph_r     <= 4'h0;
      rd_cnt_r <= 3'h0;
      if (go && !dist_bad) begin
        state_r <= nchc_pkg::ST_RUN;
      end
    end else begin
      case (kind_c)
        nchc_pkg::K_CMD, nchc_pkg::K_ADR, nchc_pkg::K_WR: begin
          ph_r <= (ph_r == nchc_pkg::WR_END_PH) ? 4'h0 : ph_r + 4'h1;
          if (ph_r == nchc_pkg::WR_END_PH) begin
            step_r <= step_r + 5'h01;
          end
        end
        nchc_pkg::K_RD: begin
          ph_r <= rd_end ? 4'h0 : ph_r + 4'h1;
          if (abort) begin
            state_r <= nchc_pkg::ST_IDLE;
          end else if (rd_end && !repeat_rd) begin
            step_r   <= step_r + 5'h01;
            rd_cnt_r <= rd_cnt_r + 3'h1;
          end
        end
        // no command goes out until the pin reports ready
        nchc_pkg::K_WAIT: begin
          if (ph_r < nchc_pkg::WB_CYC) begin
            ph_r <= ph_r + 4'h1;
          end else if (rdy_s) begin
            ph_r   <= 4'h0;
            step_r <= step_r + 5'h01;
          end
        end
        nchc_pkg::K_NOP: step_r <= step_r + 5'h01;
        default: state_r <= nchc_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      smp_r <= 8'h00;
    end else if (run && (kind_c == nchc_pkg::K_RD) && (ph_r == nchc_pkg::RD_SAMPLE_PH)) begin
      smp_r <= din_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // result flags and captured bytes

  always_ff @(posedge core_clk) begin
    if (rst) begin
      done_r     <= 1'b0;
      err_dist_r <= 1'b0;
      err_unc_r  <= 1'b0;
      fail_r     <= 1'b0;
      ecc_unc_r  <= 1'b0;
    end else if (go) begin
      done_r     <= dist_bad;
      err_dist_r <= dist_bad;
      err_unc_r  <= 1'b0;
      fail_r     <= 1'b0;
      ecc_unc_r  <= 1'b0;
    end else begin
      if ((run && (kind_c == nchc_pkg::K_END)) || abort) begin
        done_r <= 1'b1;
      end
      if (abort) begin
        err_unc_r <= 1'b1;
      end
      if (rd_end && cb_final && !repeat_rd) begin
        fail_r <= smp_r[0];
      end
      if (rd_end && (op_r == nchc_pkg::OP_ECC) && (smp_r[3:0] == 4'hF)) begin
        ecc_unc_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      stat_r <= 8'h00;
      for (int i = 0; i < nchc_pkg::ID_BYTES; i++) id_r[i] <= 8'h00;
      for (int i = 0; i < nchc_pkg::ECC_SECTORS; i++) ecc_r[i] <= 8'h00;
    end else if (rd_end) begin
      case (op_r)
        nchc_pkg::OP_ID: id_r[rd_cnt_r] <= smp_r;
        nchc_pkg::OP_ECC: begin
          if (smp_r[7:6] == 2'h0) begin
            ecc_r[smp_r[5:4]] <= smp_r;
          end
        end
        default: stat_r <= smp_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register file

  always_ff @(posedge core_clk) begin
    if (rst) begin
      op_r       <= nchc_pkg::OP_COPY;
      mod_en_r   <= 1'b0;
      wp_n_r     <= nchc_pkg::WP_N_RST;
      src_row_r  <= 17'h00000;
      dst_row_r  <= 17'h00000;
      mod_col_r  <= 12'h000;
      mod_data_r <= 8'h00;
      id_cmd_r   <= nchc_pkg::ID_CMD_RST;
      ecc_cmd_r  <= nchc_pkg::ECC_CMD_RST;
    end else if (reg_wr && !run) begin
      case (reg_addr)
        nchc_pkg::REG_CTRL: begin
          op_r     <= nchc_pkg::nchc_op_t'(reg_wdata[nchc_pkg::CTRL_OP +: 2]);
          mod_en_r <= reg_wdata[nchc_pkg::CTRL_MOD];
          wp_n_r   <= reg_wdata[nchc_pkg::CTRL_WP];
        end
        nchc_pkg::REG_SRC: src_row_r <= reg_wdata[16:0];
        nchc_pkg::REG_DST: dst_row_r <= reg_wdata[16:0];
        nchc_pkg::REG_MOD: begin
          mod_col_r  <= reg_wdata[11:0];
          mod_data_r <= reg_wdata[23:16];
        end
        nchc_pkg::REG_CODES: begin
          id_cmd_r  <= reg_wdata[7:0];
          ecc_cmd_r <= reg_wdata[15:8];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || !reg_rd) begin
      reg_rdata <= 32'h00000000;
    end else begin
      case (reg_addr)
        nchc_pkg::REG_CTRL:  reg_rdata <= {27'h0000000, wp_n_r, mod_en_r, op_r, 1'b0};
        nchc_pkg::REG_SRC:   reg_rdata <= {15'h0000, src_row_r};
        nchc_pkg::REG_DST:   reg_rdata <= {15'h0000, dst_row_r};
        nchc_pkg::REG_MOD:   reg_rdata <= {8'h00, mod_data_r, 4'h0, mod_col_r};
        nchc_pkg::REG_CODES: reg_rdata <= {16'h0000, ecc_cmd_r, id_cmd_r};
        nchc_pkg::REG_STAT:  reg_rdata <= {16'h0000, stat_r, 2'h0, ecc_unc_r, fail_r,
                                           err_unc_r, err_dist_r, done_r, run};
        nchc_pkg::REG_ID0:   reg_rdata <= {id_r[3], id_r[2], id_r[1], id_r[0]};
        nchc_pkg::REG_ID1:   reg_rdata <= {24'h000000, id_r[4]};
        nchc_pkg::REG_ECC:   reg_rdata <= {ecc_r[3], ecc_r[2], ecc_r[1], ecc_r[0]};
        default:             reg_rdata <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin drivers

  always_ff @(posedge core_clk) begin
    if (rst) begin
      nand_ce_n     <= 1'b1;
      nand_cle      <= 1'b0;
      nand_ale      <= 1'b0;
      nand_we_n     <= 1'b1;
      read_strobe_n <= 1'b1;
      nand_wp_n     <= nchc_pkg::WP_N_RST;
      data_port_o   <= 8'h00;
      data_port_oe  <= 1'b0;
      last_cmd_r    <= 8'h00;
    end else begin
      nand_ce_n     <= !run;
      nand_cle      <= run && (kind_c == nchc_pkg::K_CMD);
      nand_ale      <= run && (kind_c == nchc_pkg::K_ADR);
      nand_we_n     <= !(run && wr_type && (ph_r >= 4'h1) && (ph_r <= nchc_pkg::STROBE_CYC));
      read_strobe_n <= !(run && (kind_c == nchc_pkg::K_RD) && (ph_r >= 4'h1) &&
                         (ph_r <= nchc_pkg::RD_SAMPLE_PH));
      nand_wp_n     <= wp_n_r;
      data_port_o   <= byte_c;
      data_port_oe  <= run && wr_type;
      if (run && (kind_c == nchc_pkg::K_CMD) && (ph_r == nchc_pkg::WR_END_PH)) begin
        last_cmd_r <= byte_c;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_we_pulse;
    !nand_we_n [*3] ##1 nand_we_n;
  endsequence

  property p_we_width;
    @(posedge core_clk) disable iff (rst) $fell(nand_we_n) |-> s_we_pulse;
  endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe width wrong");

  property p_confirm_after_input;
    @(posedge core_clk) disable iff (rst)
      (!nand_we_n && nand_cle && (data_port_o == nchc_pkg::CMD_PROG))
      |-> (last_cmd_r == nchc_pkg::CMD_CB_INPUT);
  endproperty
  a_confirm_after_input: assert property (p_confirm_after_input)
    else $error("confirm not preceded by copy input");

  property p_busy_quiet;
    @(posedge core_clk) disable iff (rst)
      (!nand_we_n && nand_cle && (data_port_o != nchc_pkg::CMD_STATUS)) |-> rdy_s;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("command issued while busy");

  property p_district;
    @(posedge core_clk) disable iff (rst)
      (run && (op_r == nchc_pkg::OP_COPY) && (step_r == 5'h00) && (ph_r == 4'h0))
      |-> (src_row_r[nchc_pkg::DISTRICT_BIT] == dst_row_r[nchc_pkg::DISTRICT_BIT]);
  endproperty
  a_district: assert property (p_district) else $error("copy-back across districts");

  property p_abort_unc;
    @(posedge core_clk) disable iff (rst)
      abort |=> (!run && err_unc_r && done_r) ##1 !run;
  endproperty
  a_abort_unc: assert property (p_abort_unc) else $error("uncorrectable page not aborted");

  property p_repeat_busy;
    @(posedge core_clk) disable iff (rst)
      repeat_rd |=> (step_r == nchc_pkg::STEP_CB_FINAL) && (ph_r == 4'h0) && !done_r;
  endproperty
  a_repeat_busy: assert property (p_repeat_busy) else $error("busy status taken as final");

  property p_status_mode;
    @(posedge core_clk) disable iff (rst)
      ($fell(read_strobe_n) && cb_final) |-> (last_cmd_r == nchc_pkg::CMD_STATUS);
  endproperty
  a_status_mode: assert property (p_status_mode) else $error("status read without command");

  property p_id_count;
    @(posedge core_clk) disable iff (rst)
      (run && (op_r == nchc_pkg::OP_ID) && (kind_c == nchc_pkg::K_END))
      |-> (rd_cnt_r == 3'h5) ##1 done_r;
  endproperty
  a_id_count: assert property (p_id_count) else $error("identification count wrong");

endmodule : nchc_host

/* File: nchc_pkg.sv */
// constants, types and register map of the nand copy-back host controller
//
// Contract
// - after array read time host checks buffered page via data or status byte.
// - host may program copy-back without reloading data when no uncorrectable error.
// - copy-back program starts with 85h plus destination; programming begins at 10h.
// - host issues copy-back only when source and destination share a district.
// - after copy-back program host may read pass/fail on status bit 1; the host takes it from status bit 0.
// - host trusts pass/fail bit only for program or erase once ready; the host also aborts on status bit 0 after the 35h copy-back read.
// - while device busy host issues only status reads or reset.
package nchc_pkg;

  // commands
  localparam logic [7:0] CMD_READ     = 8'h00;
  localparam logic [7:0] CMD_CB_READ  = 8'h35;
  localparam logic [7:0] CMD_CB_INPUT = 8'h85;
  localparam logic [7:0] CMD_PROG     = 8'h10;
  localparam logic [7:0] CMD_STATUS   = 8'h70;
  // software-programmable command codes, values after reset arbitrary
  localparam logic [7:0] ID_CMD_RST   = 8'h00;
  localparam logic [7:0] ECC_CMD_RST  = 8'h00;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_STROBE_NS   = 30;
  localparam int T_WB_NS       = 100;
  localparam logic [3:0] STROBE_CYC =
    4'((T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] WB_CYC =
    4'((T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] RD_EXTRA_CYC = 4'h5;
  localparam logic [3:0] WR_END_PH    = 4'(2 * STROBE_CYC);
  localparam logic [3:0] RD_SAMPLE_PH = 4'(STROBE_CYC + RD_EXTRA_CYC);
  localparam logic [3:0] RD_END_PH    = 4'(RD_SAMPLE_PH + STROBE_CYC);

  // array geometry
  localparam int DISTRICT_BIT = 6;
  localparam int ID_BYTES     = 5;
  localparam int ECC_SECTORS  = 4;

  // sequence steps inside copy-back
  localparam logic [4:0] STEP_CB_CHECK = 5'h09;
  localparam logic [4:0] STEP_CB_FINAL = 5'h17;

  // register indices
  localparam logic [3:0] REG_CTRL  = 4'h0;
  localparam logic [3:0] REG_SRC   = 4'h1;
  localparam logic [3:0] REG_DST   = 4'h2;
  localparam logic [3:0] REG_MOD   = 4'h3;
  localparam logic [3:0] REG_CODES = 4'h4;
  localparam logic [3:0] REG_STAT  = 4'h5;
  localparam logic [3:0] REG_ID0   = 4'h6;
  localparam logic [3:0] REG_ID1   = 4'h7;
  localparam logic [3:0] REG_ECC   = 4'h8;

  // control fields
  localparam int CTRL_GO  = 0;
  localparam int CTRL_OP  = 1;
  localparam int CTRL_MOD = 3;
  localparam int CTRL_WP  = 4;
  localparam logic WP_N_RST = 1'b0;

  // status fields
  localparam int ST_BUSY     = 0;
  localparam int ST_DONE     = 1;
  localparam int ST_ERR_DIST = 2;
  localparam int ST_ERR_UNC  = 3;
  localparam int ST_FAIL     = 4;
  localparam int ST_ECC_UNC  = 5;
  localparam int ST_BYTE     = 8;

  typedef enum logic [1:0] {OP_COPY, OP_ID, OP_STATUS, OP_ECC} nchc_op_t;
  typedef enum logic [2:0] {K_CMD, K_ADR, K_WR, K_RD, K_WAIT, K_NOP, K_END} nchc_kind_t;
  typedef enum logic {ST_IDLE, ST_RUN} nchc_state_t;

endpackage : nchc_pkg

/* File: nchc_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module nchc_sync #(
  parameter int W = 9
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // take a new value only once the last two stages agree
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dout <= '0;
    end else if (s2_r == s3_r) begin
      dout <= s3_r;
    end
  end

endmodule : nchc_sync

/* File: test_nchc_host.sv */
// self-checking bench for the nand copy-back host controller
`timescale 1ns/100ps
module test_nchc_host;
  // arbitrary identification values
  localparam logic [39:0] IDS = 40'hF2_26_94_5A_C3;
  logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, fail = 0, unc = 0, e;
  logic [3:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, ecc = 0, reg_rdata, st, d;
  logic ce_n, cle, ale, we_n, re_n, wp_n, oe, rb;
  logic [7:0] dpo, dq;
  int busy_ns = 60, n_errors = 0, cmp_count = 0;
  always #5 core_clk = ~core_clk;
  nchc_host u_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .nand_ce_n(ce_n), .nand_cle(cle), .nand_ale(ale), .nand_we_n(we_n),
    .read_strobe_n(re_n), .nand_wp_n(wp_n), .data_port_o(dpo), .data_port_oe(oe),
    .data_port_i(oe ? dpo : dq), .ready_busy_pin(rb));
  nchc_dev_model #(.IDS(IDS)) u_dev (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .re_n(re_n), .wp_n(wp_n), .din(oe ? dpo : ~dpo), .fail(fail), .unc(unc), .ecc(ecc),
    .busy_ns(busy_ns), .dq(dq), .rb(rb));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic go(input logic [31:0] c);
    wr(nchc_pkg::REG_CTRL, c | 32'h1);
    for (int i = 0; i < 3000; i++) begin
      rd(nchc_pkg::REG_STAT, st);
      if (st[1]) break;
    end
    chk(st[1], 1'b1, "op done");
  endtask : go
  task automatic cb(input int k);
    logic [16:0] s, t;
    logic [11:0] c;
    logic [7:0] v;
    int n0, m0;
    s = 17'($urandom);
    t = 17'($urandom);
    t[6] = s[6] ^ (k == 3);
    c = 12'($urandom % 2112);
    v = 8'($urandom);
    busy_ns = k[0] ? 2000 : 60;
    fail = (k == 1);
    unc = (k == 2);
    n0 = u_dev.nprog;
    m0 = u_dev.ncmd;
    wr(4'h1, 32'(s));
    wr(4'h2, 32'(t));
    wr(4'h3, {8'h0, v, 4'h0, c});
    go((k == 0) ? 32'h10 : 32'h18);
    chk(st[4:0], {fail, unc, k == 3, 2'b10}, "copy stat");
    chk(u_dev.nprog, n0 + (k < 2), "programs");
    if (k == 3) chk(u_dev.ncmd, m0, "pins moved");
    else chk(st[15:8], {3'b111, 4'h0, fail | unc}, "cb status");
    if (k < 2) begin
      chk(u_dev.prow, t, "dest row");
      chk(u_dev.pbuf[c], (k == 0) ? 8'(s + c) : v, "mod byte");
      chk(u_dev.pbuf[c ^ 12'h1], 8'(s + (c ^ 12'h1)), "kept byte");
    end
    $display("copy test %0d done", k);
  endtask : cb
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////
  initial begin
    #900000;
    n_errors++;
    summarize();
  end
  initial begin
    void'($urandom(32'h55796DBB));
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rd(4'h0, d);
    chk(d, 0, "ctrl reset");
    chk(wp_n, 0, "wp reset");
    rd(4'h9, d);
    chk(d, 0, "unmapped");
    wr(4'h4, 32'h7AA5);
    go(32'h12);
    rd(4'h6, d);
    chk(d, IDS[31:0], "id bytes");
    rd(4'h7, d);
    chk(d, {24'h0, IDS[39:32]}, "id byte5");
    $display("id test done");
    for (int w = 0; w < 2; w++) begin
      go(32'(w * 16 + 4));
      chk(st[15:8], {w[0], 2'b11, 5'h0}, "status");
      chk(wp_n, w[0], "wp pin");
    end
    $display("status test done");
    for (int r = 0; r < 3; r++) begin
      e = 1'b0;
      for (int i = 0; i < 4; i++) begin
        d = $urandom % 10;
        ecc[8*i +: 8] = {4'(i), (d == 9) ? 4'hF : 4'(d)};
        e = e | (d == 9);
      end
      go(32'h16);
      chk(st[5], e, "ecc unc");
      rd(4'h8, d);
      chk(d, ecc, "ecc bytes");
    end
    $display("ecc test done");
    for (int k = 0; k < 4; k++) cb(k);
    summarize();
  end
endmodule : test_nchc_host
